// ---- rtl/gtsli_top.sv ----
// Gamma tap select and line inversion control with an AHB-Lite register slave.
// Assumes frame_start and line_strobe are one-cycle pulses from raster timing on hclk.
//
// Function
// R01 - High gradient resistor is four unit R per code step, 0 to 28.
// R02 - Low gradient code maps to 0,1,2,16,20,24,28 R per table.
// R03 - First amplitude two R per step; second amplitude one R per step.
// R04 - Reference output j selects ladder tap 8*(j-1)+k+1, taps 1 to 48.
// R05 - Separate positive and negative ladder paths with their own codes.
// R06 - In 8-colour mode only extreme levels used; middle supplies off.
// R07 - In 8-colour mode fine tap codes have no effect.
// R08 - Host must make frame memory colours all-zero or all-one first.
// R09 - Polarity alternates per frame or every n rows, n from 1 to 64.
// R10 - Rows between polarity changes equals row count field plus one.
// R11 - Host should set inversion XOR enable during row inversion.
// R12 - Frame inversion flips every frame, then blanks 8 lines gate-off.
// R13 - Row inversion blanks 8 lines only after full screen scanned.
// R14 - Row counter restarts at each frame start.
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module gtsli_top (
  // Clock, reset, enable
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      ce,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // Raster timing
  input  wire logic                      frame_start,
  input  wire logic                      line_strobe,
  // Panel drive
  output gtsli_pkg::gtsli_ladder_s       pos_ladder,
  output gtsli_pkg::gtsli_ladder_s       neg_ladder,
  output logic                           drive_polarity,
  output logic                           gate_off_blank,
  output logic                           mid_level_supply_en
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                       color8_reg, color8_next;
  logic                       row_mode_reg, row_mode_next;
  logic                       xor_en_reg, xor_en_next;
  logic [5:0]                 row_count_reg, row_count_next;
  gtsli_pkg::gtsli_gamma_s    pos_codes_reg, pos_codes_next;
  gtsli_pkg::gtsli_gamma_s    neg_codes_reg, neg_codes_next;
  logic                       wr_pend_reg, wr_pend_next;
  logic [7:0]                 wr_addr_reg, wr_addr_next;
  logic [31:0]                hrdata_reg, hrdata_next;

  // ----------------------------------------------------------------
  // Polarity state
  // ----------------------------------------------------------------
  logic                       frame_pol_reg, frame_pol_next;
  logic                       row_pol_reg, row_pol_next;
  logic [5:0]                 row_cnt_reg, row_cnt_next;
  logic [3:0]                 blank_cnt_reg, blank_cnt_next;
  logic                       pol_out_reg, pol_out_next;
  logic                       blank_out_reg, blank_out_next;
  logic                       supply_reg, supply_next;
  gtsli_pkg::gtsli_ladder_s   pos_dec, neg_dec;
  gtsli_pkg::gtsli_ladder_s   pos_out_reg, neg_out_reg;

  logic                       addr_phase;
  logic [7:0]                 rd_addr;

  assign addr_phase = hsel && hready && htrans[1];
  assign rd_addr    = haddr[gtsli_pkg::ADDR_LSB_W-1:0];

  // ----------------------------------------------------------------
  // Field packing helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] adj_word(input gtsli_pkg::gtsli_gamma_s c);
    logic [31:0] w;
    w = 32'h0;
    w[gtsli_pkg::ADJ_HIGH_LSB +: 3] = c.gradient_high_code;
    w[gtsli_pkg::ADJ_LOW_LSB  +: 3] = c.gradient_low_code;
    w[gtsli_pkg::ADJ_AMP1_LSB +: 4] = c.first_amplitude_code;
    w[gtsli_pkg::ADJ_AMP2_LSB +: 5] = c.second_amplitude_code;
    return w;
  endfunction

  function automatic logic [31:0] tap_word(input logic [17:0] t);
    logic [31:0] w;
    w = 32'h0;
    for (int i = 0; i < gtsli_pkg::REF_OUTPUTS; i++) begin
      w[gtsli_pkg::TAP_FIELD_STRIDE*i +: 3] = t[3*i +: 3];
    end
    return w;
  endfunction

  function automatic logic [17:0] tap_field(input logic [31:0] w);
    logic [17:0] t;
    t = 18'h0;
    for (int i = 0; i < gtsli_pkg::REF_OUTPUTS; i++) begin
      t[3*i +: 3] = w[gtsli_pkg::TAP_FIELD_STRIDE*i +: 3];
    end
    return t;
  endfunction

  function automatic gtsli_pkg::gtsli_gamma_s adj_load(input gtsli_pkg::gtsli_gamma_s c,
                                                      input logic [31:0] w);
    gtsli_pkg::gtsli_gamma_s r;
    r = c;
    r.gradient_high_code    = w[gtsli_pkg::ADJ_HIGH_LSB +: 3];
    r.gradient_low_code     = w[gtsli_pkg::ADJ_LOW_LSB  +: 3];
    r.first_amplitude_code  = w[gtsli_pkg::ADJ_AMP1_LSB +: 4];
    r.second_amplitude_code = w[gtsli_pkg::ADJ_AMP2_LSB +: 5];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: zero wait states, write data taken in data phase
  // ----------------------------------------------------------------
  always_comb begin
    color8_next    = color8_reg;
    row_mode_next  = row_mode_reg;
    xor_en_next    = xor_en_reg;
    row_count_next = row_count_reg;
    pos_codes_next = pos_codes_reg;
    neg_codes_next = neg_codes_reg;
    wr_pend_next   = addr_phase && hwrite;
    wr_addr_next   = addr_phase ? rd_addr : wr_addr_reg;
    hrdata_next    = 32'h0;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        gtsli_pkg::CTRL_OFS: begin
          color8_next    = hwdata[gtsli_pkg::CTRL_COLOR8_BIT];
          row_mode_next  = hwdata[gtsli_pkg::CTRL_ROWMODE_BIT];
          xor_en_next    = hwdata[gtsli_pkg::CTRL_XOR_BIT];
          row_count_next = hwdata[gtsli_pkg::CTRL_ROWCNT_LSB +: gtsli_pkg::ROWCNT_W];
        end
        gtsli_pkg::POS_ADJ_OFS: pos_codes_next = adj_load(pos_codes_reg, hwdata);     // [R05]
        gtsli_pkg::POS_TAP_OFS: pos_codes_next.fine_tap_code = tap_field(hwdata);
        gtsli_pkg::NEG_ADJ_OFS: neg_codes_next = adj_load(neg_codes_reg, hwdata);     // [R05]
        gtsli_pkg::NEG_TAP_OFS: neg_codes_next.fine_tap_code = tap_field(hwdata);
        default: ;
      endcase
    end
    if (addr_phase && !hwrite) begin
      unique case (rd_addr)
        gtsli_pkg::CTRL_OFS: begin
          hrdata_next[gtsli_pkg::CTRL_COLOR8_BIT]  = color8_reg;
          hrdata_next[gtsli_pkg::CTRL_ROWMODE_BIT] = row_mode_reg;
          hrdata_next[gtsli_pkg::CTRL_XOR_BIT]     = xor_en_reg;
          hrdata_next[gtsli_pkg::CTRL_ROWCNT_LSB +: gtsli_pkg::ROWCNT_W] = row_count_reg;
        end
        gtsli_pkg::POS_ADJ_OFS: hrdata_next = adj_word(pos_codes_reg);
        gtsli_pkg::POS_TAP_OFS: hrdata_next = tap_word(pos_codes_reg.fine_tap_code);
        gtsli_pkg::NEG_ADJ_OFS: hrdata_next = adj_word(neg_codes_reg);
        gtsli_pkg::NEG_TAP_OFS: hrdata_next = tap_word(neg_codes_reg.fine_tap_code);
        gtsli_pkg::STATUS_OFS: begin
          hrdata_next[gtsli_pkg::STAT_POL_BIT]   = pol_out_reg;
          hrdata_next[gtsli_pkg::STAT_BLANK_BIT] = blank_out_reg;
          hrdata_next[gtsli_pkg::STAT_ROWCNT_LSB +: gtsli_pkg::ROWCNT_W] = row_cnt_reg;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      color8_reg    <= 1'h0;
      row_mode_reg  <= 1'h0;
      xor_en_reg    <= 1'h0;
      row_count_reg <= 6'h00;
      pos_codes_reg <= '0;
      neg_codes_reg <= '0;
      wr_pend_reg   <= 1'h0;
      wr_addr_reg   <= 8'h00;
      hrdata_reg    <= 32'h0;
    end else if (ce) begin
      color8_reg    <= color8_next;
      row_mode_reg  <= row_mode_next;
      xor_en_reg    <= xor_en_next;
      row_count_reg <= row_count_next;
      pos_codes_reg <= pos_codes_next;
      neg_codes_reg <= neg_codes_next;
      wr_pend_reg   <= wr_pend_next;
      wr_addr_reg   <= wr_addr_next;
      hrdata_reg    <= hrdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Polarity alternation and blanking
  // ----------------------------------------------------------------
  always_comb begin
    frame_pol_next = frame_pol_reg;
    row_pol_next   = row_pol_reg;
    row_cnt_next   = row_cnt_reg;
    blank_cnt_next = blank_cnt_reg;
    if (frame_start) begin
      // Frame start also closes the previous screen, so blanking goes here
      frame_pol_next = !frame_pol_reg;                                              // [R09] [R12]
      row_pol_next   = 1'h0;                                                        // [R14]
      row_cnt_next   = 6'h00;                                                       // [R14]
      blank_cnt_next = gtsli_pkg::BLANK_LINES;                                      // [R12] [R13]
    end else if (line_strobe) begin
      if (blank_cnt_reg != 4'h0) begin
        blank_cnt_next = blank_cnt_reg - 4'h1;
      end else if (row_mode_reg) begin
        // Row polarity changes carry no blank of their own
        if (row_cnt_reg == row_count_reg) begin                                      // [R10] [R13]
          row_cnt_next = 6'h00;
          row_pol_next = !row_pol_reg;                                              // [R09]
        end else begin
          row_cnt_next = row_cnt_reg + 6'h01;
        end
      end
    end
    pol_out_next   = row_mode_next_pol(row_pol_next, frame_pol_next);
    blank_out_next = (blank_cnt_next != 4'h0);                                      // [R12]
    supply_next    = !color8_reg;                                                   // [R06]
  end

  // XOR with frame polarity cancels DC when host enables it
  function automatic logic row_mode_next_pol(input logic rp, input logic fp);
    return row_mode_reg ? (rp ^ (xor_en_reg & fp)) : fp;                            // [R11]
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_pol_reg <= 1'h0;
      row_pol_reg   <= 1'h0;
      row_cnt_reg   <= 6'h00;
      blank_cnt_reg <= 4'h0;
      pol_out_reg   <= 1'h0;
      blank_out_reg <= 1'h0;
      supply_reg    <= 1'h1;
      pos_out_reg   <= '0;
      neg_out_reg   <= '0;
    end else if (ce) begin
      frame_pol_reg <= frame_pol_next;
      row_pol_reg   <= row_pol_next;
      row_cnt_reg   <= row_cnt_next;
      blank_cnt_reg <= blank_cnt_next;
      pol_out_reg   <= pol_out_next;
      blank_out_reg <= blank_out_next;
      supply_reg    <= supply_next;
      pos_out_reg   <= pos_dec;
      neg_out_reg   <= neg_dec;
    end
  end

  // ----------------------------------------------------------------
  // Two independent ladder paths
  // ----------------------------------------------------------------
  gtsli_decode u_pos_dec (                                                          // [R05]
    .codes       (pos_codes_reg),
    .color8_mode (color8_reg),
    .ladder      (pos_dec)
  );

  gtsli_decode u_neg_dec (                                                          // [R05]
    .codes       (neg_codes_reg),
    .color8_mode (color8_reg),
    .ladder      (neg_dec)
  );

  assign hrdata              = hrdata_reg;
  assign hreadyout           = 1'h1;
  assign hresp               = 1'h0;
  assign pos_ladder          = pos_out_reg;
  assign neg_ladder          = neg_out_reg;
  assign drive_polarity      = pol_out_reg;
  assign gate_off_blank      = blank_out_reg;
  assign mid_level_supply_en = supply_reg;

endmodule
`default_nettype wire

// ---- rtl/gtsli_pkg.sv ----
// Constants, register map and carrier types for the gamma tap select and line inversion block.
// Assumes a 32-bit AHB-Lite register bus and raster timing strobes on the same clock.
package gtsli_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] POS_ADJ_OFS   = 8'h04;
  localparam logic [7:0] POS_TAP_OFS   = 8'h08;
  localparam logic [7:0] NEG_ADJ_OFS   = 8'h0c;
  localparam logic [7:0] NEG_TAP_OFS   = 8'h10;
  localparam logic [7:0] STATUS_OFS    = 8'h14;
  localparam int         ADDR_LSB_W    = 8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_COLOR8_BIT   = 0;
  localparam int CTRL_ROWMODE_BIT  = 1;
  localparam int CTRL_XOR_BIT      = 2;
  localparam int CTRL_ROWCNT_LSB   = 8;
  localparam int ADJ_HIGH_LSB      = 0;
  localparam int ADJ_LOW_LSB       = 4;
  localparam int ADJ_AMP1_LSB      = 8;
  localparam int ADJ_AMP2_LSB      = 16;
  localparam int TAP_FIELD_STRIDE  = 4;
  localparam int STAT_POL_BIT      = 0;
  localparam int STAT_BLANK_BIT    = 1;
  localparam int STAT_ROWCNT_LSB   = 8;

  // ----------------------------------------------------------------
  // Ladder constants
  // ----------------------------------------------------------------
  localparam int         REF_OUTPUTS    = 6;
  localparam int         ROWCNT_W       = 6;
  localparam logic [5:0] TAPS_PER_GROUP = 6'h08;
  localparam logic [5:0] TAP_BASE       = 6'h01;
  localparam logic [1:0] HIGH_STEP_SHIFT = 2'h2;
  localparam logic [3:0] BLANK_LINES    = 4'h8;
  // Low-side gradient resistance in unit R, indexed by code; code 001 is unlisted
  localparam logic [4:0] LOW_GRAD_R [8] = '{5'h00, 5'h00, 5'h01, 5'h02, 5'h10, 5'h14, 5'h18, 5'h1c};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  gradient_high_code;
    logic [2:0]  gradient_low_code;
    logic [3:0]  first_amplitude_code;
    logic [4:0]  second_amplitude_code;
    logic [17:0] fine_tap_code;
  } gtsli_gamma_s;

  typedef struct packed {
    logic [4:0]  high_gradient_resistor;
    logic [4:0]  low_gradient_resistor;
    logic [4:0]  first_amplitude_resistor;
    logic [4:0]  second_amplitude_resistor;
    logic [35:0] ladder_tap;
  } gtsli_ladder_s;

endpackage

// ---- rtl/gtsli_decode.sv ----
// Decoder for one polarity path: gamma codes to ladder resistor settings and selector taps.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module gtsli_decode (
  // Codes
  input  wire gtsli_pkg::gtsli_gamma_s   codes,
  input  wire logic                      color8_mode,
  // Ladder settings
  output gtsli_pkg::gtsli_ladder_s       ladder
);

  // Taps gathered in a net so that one process alone writes the carrier
  wire logic [35:0] tap_w;

  always_comb begin
    ladder.high_gradient_resistor    = {codes.gradient_high_code, 2'h0};            // [R01]
    ladder.low_gradient_resistor     = gtsli_pkg::LOW_GRAD_R[codes.gradient_low_code]; // [R02]
    ladder.first_amplitude_resistor  = {codes.first_amplitude_code, 1'h0};         // [R03]
    ladder.second_amplitude_resistor = codes.second_amplitude_code;                // [R03]
    ladder.ladder_tap                = tap_w;                                      // [R04]
  end

  // ----------------------------------------------------------------
  // Selector taps
  // ----------------------------------------------------------------
  for (genvar i = 0; i < gtsli_pkg::REF_OUTPUTS; i++) begin : g_tap
    logic [2:0] k;
    // Fine codes are don't-care in 8-colour mode
    assign k = color8_mode ? 3'h0 : codes.fine_tap_code[3*i +: 3];                 // [R07]
    assign tap_w[6*i +: 6]             = 6'(gtsli_pkg::TAPS_PER_GROUP * 6'(i)) + {3'h0, k}
                                       + gtsli_pkg::TAP_BASE;                         // [R04]
  end

endmodule
`default_nettype wire

// ---- tb/gtsli_chk_sva.sv ----
// Concurrent checks for the gamma tap select and line inversion block.
// Sees only the top ports; clock enable is assumed high, and the bench drops it only for one ignored control write.
`timescale 1ns/10ps
`default_nettype none
module gtsli_chk (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // Bus request
  input  wire logic                     hsel,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic                     hready,
  // Raster and panel side
  input  wire logic                     frame_start,
  input  wire logic                     line_strobe,
  input  wire gtsli_pkg::gtsli_ladder_s pos_ladder,
  input  wire gtsli_pkg::gtsli_ladder_s neg_ladder,
  input  wire logic                     drive_polarity,
  input  wire logic                     gate_off_blank,
  input  wire logic                     mid_level_supply_en
);
  logic       wr_dp_reg, wr_dp_next, wr_lag_reg, wr_lag_next, taps_ok, base_ok;
  // Ladder outputs hold zero until the first edge after reset loads a decode
  logic       live_reg;
  logic [3:0] cnt_reg, cnt_next;
  logic [5:0] tp, tn;
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  always_comb begin
    wr_dp_next = hsel & hready & htrans[1] & hwrite;
    wr_lag_next = wr_dp_reg;
    cnt_next = cnt_reg;
    if (frame_start) begin
      cnt_next = 4'h0;
    end else if (gate_off_blank && line_strobe) begin
      cnt_next = cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_reg <= 1'b0;
      wr_lag_reg <= 1'b0;
      cnt_reg <= 4'h0;
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
      wr_dp_reg <= wr_dp_next;
      wr_lag_reg <= wr_lag_next;
      cnt_reg <= cnt_next;
    end
  end
  always_comb begin
    taps_ok = 1'b1;
    base_ok = 1'b1;
    for (int j = 0; j < 6; j++) begin
      tp = pos_ladder.ladder_tap[6*j +: 6];
      tn = neg_ladder.ladder_tap[6*j +: 6];
      taps_ok &= tp > 6'(8*j) && tp <= 6'(8*j+8) && tn > 6'(8*j) && tn <= 6'(8*j+8);
      base_ok &= tp == 6'(8*j+1) && tn == 6'(8*j+1);
    end
  end
  function automatic logic low_ok(input logic [4:0] r);
    return r inside {5'h00, 5'h01, 5'h02, 5'h10, 5'h14, 5'h18, 5'h1c};
  endfunction
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_high_step: assert property (pos_ladder.high_gradient_resistor[1:0] == 2'h0
    && neg_ladder.high_gradient_resistor[1:0] == 2'h0) else $error("high gradient step wrong");
  chk_low_table: assert property (low_ok(pos_ladder.low_gradient_resistor)
    && low_ok(neg_ladder.low_gradient_resistor)) else $error("low gradient value off table");
  chk_amp_step: assert property (!pos_ladder.first_amplitude_resistor[0]
    && !neg_ladder.first_amplitude_resistor[0]) else $error("first amplitude step wrong");
  chk_tap_window: assert property (live_reg |-> taps_ok) else $error("tap outside its group");
  chk_color8_taps: assert property (!mid_level_supply_en |-> base_ok)
    else $error("fine codes act in 8-colour mode");
  chk_blank_rise: assert property (frame_start |=> gate_off_blank)
    else $error("no blank after frame start");
  chk_blank_hold: assert property (gate_off_blank && !line_strobe && !frame_start |=> gate_off_blank)
    else $error("blank ended without a line");
  chk_blank_len: assert property ($fell(gate_off_blank) |-> cnt_reg == 4'h8 && $past(line_strobe))
    else $error("blank not eight lines");
  chk_pol_cause: assert property ($changed(drive_polarity)
    |-> $past(frame_start) || $past(line_strobe) || $past(wr_dp_reg) || $past(wr_lag_reg))
    else $error("polarity changed without cause");
  chk_blank_rows: assert property (gate_off_blank && !frame_start && !wr_dp_reg && !wr_lag_reg
    |=> $stable(drive_polarity)) else $error("rows counted during blank");
  cover property (frame_start ##1 gate_off_blank);
  cover property ($fell(gate_off_blank));
  cover property (!mid_level_supply_en);
endmodule
bind gtsli_top gtsli_chk u_gtsli_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .frame_start, .line_strobe,
  .pos_ladder, .neg_ladder, .drive_polarity, .gate_off_blank, .mid_level_supply_en
);
`default_nettype wire

// ---- tb/gtsli_panel.sv ----
// Raster source and panel probe for the gamma tap select block.
// Started by the bench; records blank and polarity after every pulse.
`timescale 1ns/10ps
`default_nettype none
module gtsli_panel (
  // Clock
  input  wire logic hclk,
  // Raster timing into the device
  output var logic  frame_start,
  output var logic  line_strobe,
  // Levels seen by the source drivers
  input  wire logic drive_polarity,
  input  wire logic gate_off_blank
);
  logic [1:0] seen_q [$];
  initial begin
    frame_start = 1'b0;
    line_strobe = 1'b0;
  end
  // Random gaps give both prompt and slow line periods
  task automatic run_frame(input int lines);
    @(posedge hclk);
    frame_start <= 1'b1;
    @(posedge hclk);
    frame_start <= 1'b0;
    #1;
    seen_q.push_back({gate_off_blank, drive_polarity});
    for (int s = 0; s < lines; s++) begin
      repeat ($urandom_range(3, 0)) @(posedge hclk);
      @(posedge hclk);
      line_strobe <= 1'b1;
      @(posedge hclk);
      line_strobe <= 1'b0;
      #1;
      seen_q.push_back({gate_off_blank, drive_polarity});
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_gtsli_top.sv ----
// Self-checking bench for the gamma tap select and line inversion block.
// Bus master on AHB-Lite, raster source in the panel model, clock enable held high except during one control write.
`timescale 1ns/10ps
`default_nettype none
module tb_gtsli_top;
  logic                     hclk, hready, hreadyout, hresp, frame_start, line_strobe;
  logic                     hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ce = 1'b1;
  logic [1:0]               htrans = 2'h0;
  logic [2:0]               hsize = 3'h2;
  logic [31:0]              haddr = 32'h0, hwdata = 32'h0, hrdata, rd, adj_p, tap_p, adj_n, tap_n;
  logic                     drive_polarity, gate_off_blank, mid_level_supply_en;
  logic [1:0]               pe;
  gtsli_pkg::gtsli_ladder_s pos_ladder, neg_ladder;
  int                       n_fail = 0, cmp_count = 0, fpol = 0;
  int                       cfg [4][3] = '{'{0, 0, 12}, '{1, 0, 12}, '{1, 2, 18}, '{1, 63, 76}};
  assign hready = hreadyout;
  gtsli_top u_gtsli_top (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .frame_start, .line_strobe, .pos_ladder, .neg_ladder,
    .drive_polarity, .gate_off_blank, .mid_level_supply_en);
  gtsli_panel u_gtsli_panel (.hclk, .frame_start, .line_strobe, .drive_polarity, .gate_off_blank);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // Compare, bus and model helpers
  // ----------------------------------------------------------------
  task automatic tally(input logic ok, input string what);
    cmp_count++;
    if (!ok) begin
      n_fail++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, exp);
    tally(got === exp, "register");
  endtask
  task automatic chk_lad(input gtsli_pkg::gtsli_ladder_s got, exp);
    tally(got === exp, "ladder");
  endtask
  task automatic chk_pan(input logic [1:0] got, exp);
    tally(got === exp, "panel level");
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr_rd(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    bus(1'b0, a, 32'h0, q);
    chk_reg(q, d);
    chk_reg({30'h0, hreadyout, hresp}, 32'h2);
  endtask
  function automatic gtsli_pkg::gtsli_ladder_s exp_lad(input logic [31:0] adj, tap, input logic c8);
    int lowt [8] = '{0, 0, 1, 2, 16, 20, 24, 28};
    exp_lad.high_gradient_resistor = 5'(4 * adj[2:0]);
    exp_lad.low_gradient_resistor = 5'(lowt[adj[6:4]]);
    exp_lad.first_amplitude_resistor = 5'(2 * adj[11:8]);
    exp_lad.second_amplitude_resistor = adj[20:16];
    for (int j = 0; j < 6; j++) begin
      exp_lad.ladder_tap[6*j +: 6] = 6'(8 * j + (c8 ? 0 : tap[4*j +: 3]) + 1);
    end
  endfunction
  // Blank for the first eight lines; rows counted only after it
  function automatic logic [1:0] exp_pan(input int row, n, s, fp);
    int k;
    k = (s > 8) ? s - 8 : 0;
    return {s < 8, row ? 1'((k / n) % 2) ^ 1'(fp) : 1'(fp)};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h9ebf253f));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk_lad(pos_ladder, exp_lad(32'h0, 32'h0, 1'b0));
    chk_pan({gate_off_blank, drive_polarity}, 2'h0);
    @(posedge hclk);
    for (int i = 0; i < 32; i++) begin
      adj_p = {11'h0, 5'(i), 4'h0, 4'(i), 1'b0, 3'(i + 3), 1'b0, 3'(i)};
      adj_n = {11'h0, 5'(31 - i), 4'h0, 4'(15 - i), 1'b0, 3'(i), 1'b0, 3'(7 - i)};
      tap_p = $urandom & 32'h00777777;
      tap_n = $urandom & 32'h00777777;
      wr_rd(32'(gtsli_pkg::POS_ADJ_OFS), adj_p);
      wr_rd(32'(gtsli_pkg::POS_TAP_OFS), tap_p);
      wr_rd(32'(gtsli_pkg::NEG_ADJ_OFS), adj_n);
      wr_rd(32'(gtsli_pkg::NEG_TAP_OFS), tap_n);
      repeat (2) @(posedge hclk);
      #1;
      chk_lad(pos_ladder, exp_lad(adj_p, tap_p, 1'b0));
      chk_lad(neg_ladder, exp_lad(adj_n, tap_n, 1'b0));
      @(posedge hclk);
    end
    // Frame memory is taken as already holding only extreme codes
    wr_rd(32'(gtsli_pkg::CTRL_OFS), 32'h1);
    repeat (2) @(posedge hclk);
    #1;
    chk_pan({1'b0, mid_level_supply_en}, 2'h0);
    chk_lad(pos_ladder, exp_lad(adj_p, tap_p, 1'b1));
    chk_lad(neg_ladder, exp_lad(adj_n, tap_n, 1'b1));
    @(posedge hclk);
    bus(1'b1, 32'h18, 32'hffffffff, rd);
    bus(1'b0, 32'h18, 32'h0, rd);
    chk_reg(rd, 32'h0);
    // A write while the clock enable is low must leave 8-colour mode on
    ce <= 1'b0;
    bus(1'b1, 32'(gtsli_pkg::CTRL_OFS), 32'h0, rd);
    ce <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    chk_pan({1'b0, mid_level_supply_en}, 2'h0);
    @(posedge hclk);
    for (int c = 0; c < 4; c++) begin
      // Row mode always runs with the XOR enable set
      wr_rd(32'(gtsli_pkg::CTRL_OFS), 32'(cfg[c][1] << 8 | cfg[c][0] * 6));
      repeat (2) begin
        u_gtsli_panel.seen_q.delete();
        u_gtsli_panel.run_frame(cfg[c][2]);
        fpol ^= 1;
        for (int s = 0; s <= cfg[c][2]; s++) begin
          pe = exp_pan(cfg[c][0], cfg[c][1] + 1, s, fpol);
          chk_pan(u_gtsli_panel.seen_q[s], pe);
        end
      end
      @(posedge hclk);
      bus(1'b0, 32'(gtsli_pkg::STATUS_OFS), 32'h0, rd);
      chk_reg(rd & 32'h3, {30'h0, pe});
      chk_pan({1'b0, mid_level_supply_en}, 2'h1);
    end
    end_of_test();
  end
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
